// >>> verilog/pad_io_pkg.sv
/*
 Constants shared by the pad I/O port block: port widths, pin positions,
 control bit positions, reset values and sink mode encodings.
 Assumes a single 40 MHz system clock and an active-low asynchronous reset.
*/
`default_nettype none
package pad_io_pkg;
  localparam int PA_W = 8;
  localparam int PB_W = 6;
  // Pin positions
  localparam int PA_XOUT = 7;
  localparam int PA_XIN = 6;
  localparam int PA_RST = 5;
  localparam int PA_CKI_A = 4;
  localparam int PA_IR = 3;
  localparam int PA_CKI_B = 1;
  localparam int PB_CMP = 3;
  localparam int PB_PWM2 = 2;
  localparam int PB_IRQ1 = 1;
  localparam int PB_IRQ0 = 0;
  // Control bit positions
  localparam int PWR_PA5_PH_BIT = 4;
  localparam int PAPH_PA5_PL_BIT = 5;
  localparam int PL_PB_LSB = 4;
  localparam int FLAG_PORT_CHG_BIT = 1;
  localparam int EN_PORT_CHG_BIT = 1;
  localparam int GLOBAL_IRQ_EN_BIT = 7;
  localparam int EDGE_IRQ0_SEL_BIT = 4;
  localparam int EDGE_IRQ1_SEL_BIT = 5;
  localparam int IR_EN_BIT = 0;
  // Reset values
  localparam logic [7:0] RST_PA = 8'h00;
  localparam logic [5:0] RST_PB = 6'h00;
  localparam logic [7:0] RST_DIR_A = 8'hFF;
  localparam logic [5:0] RST_DIR_B = 6'h3F;
  // Sink strength codes
  typedef enum logic [1:0] {
    SINK_SMALL = 2'h0,
    SINK_NORMAL = 2'h1,
    SINK_LARGE = 2'h3,
    SINK_CONST = 2'h2
  } sink_mode_t;
endpackage
`default_nettype wire

// >>> verilog/pad_cell.sv
/*
 One general-purpose pad cell: output path, open-drain, pulls and read select.
 Assumes the pad level input is synchronous to the system clock.
*/
`default_nettype none
module pad_cell (
  input wire logic dir_in, // 1 = input
  input wire logic out_val, // Value to drive
  input wire logic force_out, // Peripheral forces output
  input wire logic od_en, // Open-drain output
  input wire logic ph_en, // Pull-high request
  input wire logic pl_en, // Pull-low request
  input wire logic pad_i, // Pad level
  input wire logic rd_latch, // 1 = read latch
  output logic pad_o, // Pad drive value
  output logic pad_oe_n, // Low while driving
  output logic pu_on, // Pull-high active
  output logic pd_on, // Pull-low active
  output logic rd_val // Value seen by port read
);
  wire is_out = force_out | ~dir_in;
  // Open-drain releases the pad instead of driving a one
  wire drive = is_out & ~(od_en & out_val);
  assign pad_o = out_val;
  assign pad_oe_n = ~drive;
  assign pu_on = ph_en & ~is_out;
  assign pd_on = pl_en & ~is_out;
  assign rd_val = rd_latch ? out_val : pad_i;
endmodule
`default_nettype wire

// >>> verilog/pad_io_port.sv
/*
 Fourteen-pad I/O port block with pin multiplexing, level-change flag,
 external interrupt steering, carrier and clock pad reuse.
 Control bits arrive as plain ports from the core's register file; pads are
 five signals each, resolved outside.
*/
`default_nettype none
module pad_io_port (
  input wire logic clk_sys, // System clock, 40 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic data_a_we, // Write strobe for port A data
  input wire logic data_b_we, // Write strobe for port B data
  input wire logic [7:0] wdata, // Write data
  output logic [7:0] data_a, // Port A read value
  output logic [5:0] data_b, // Port B read value
  input wire logic [7:0] data_a_direction, // 1 = input
  input wire logic [5:0] data_b_direction, // 1 = input
  input wire logic [7:0] rd_latch_a, // 1 = read latch, port A
  input wire logic [5:0] rd_latch_b, // 1 = read latch, port B
  input wire logic [7:0] data_a_pullhigh_ctrl, // Pull-high A, bit 5 pull-low A5
  input wire logic [5:0] data_b_pullhigh_ctrl, // Pull-high B
  input wire logic [7:0] pulllow_ctrl, // Pull-low A3:0, B3:0
  input wire logic [7:0] power_ctrl, // Bit 4 pull-high A5
  input wire logic [5:0] data_b_opendrain_ctrl, // Open-drain B
  input wire logic [7:0] data_a_wake_mask, // Level-change select A
  input wire logic [5:0] data_b_wake_mask, // Level-change select B
  input wire logic flag_clr_we, // Software write to flag register
  input wire logic [7:0] flag_wdata, // Flag write data
  output logic [7:0] irq_flag_reg, // Flag register, bit 1 port change
  input wire logic [7:0] irq_enable_reg, // Interrupt enables
  input wire logic [7:0] power_ctrl_one, // Bit 7 global enable
  output logic port_irq, // Port change request
  input wire logic [7:0] ext_irq_edge_reg, // Bits 5:4 external selects
  output logic ext_irq0_pin, // External interrupt 0 level
  output logic ext_irq1_pin, // External interrupt 1 level
  input wire logic [7:0] ir_ctrl_reg, // Bit 0 carrier enable
  input wire logic ir_large_cfg, // Carrier current option large
  input wire logic ir_carrier, // Carrier waveform
  input wire logic rst_pad_cfg, // Pad A5 is reset input
  output logic ext_rst_n, // External reset, active low
  input wire logic xtal_cfg, // Crystal mode
  input wire logic clk_out_cfg, // Instruction clock output
  input wire logic instr_clk, // Instruction clock
  output logic xtal_in, // Crystal input level
  input wire logic tmr0_src_sel, // Timer0 source select
  input wire logic tmr0_lowclk_sel, // Timer0 low-clock select
  input wire logic tmr1_src_sel, // Timer1 source select
  input wire logic tmr2_src_sel, // Timer2 source select
  input wire logic tmr3_src_sel, // Timer3 source select
  output logic tmr0_ext_clk, // Timer0 external clock
  output logic tmr1_ext_clk, // Timer1 external clock
  output logic tmr2_ext_clk, // Timer2 external clock
  output logic tmr3_ext_clk, // Timer3 external clock
  input wire logic cmp_out_en, // Comparator to pad B3
  input wire logic cmp_out, // Comparator value
  input wire logic pwm_one_out_en, // PWM1 to pad B3
  input wire logic pwm_one, // PWM1 value
  input wire logic buzzer_one_en, // Buzzer1 to pad B3
  input wire logic buzzer_one, // Buzzer1 value
  input wire logic pwm_two_out_en, // PWM2 to pad B2
  input wire logic pwm_two, // PWM2 value
  input wire logic buzzer_two_en, // Buzzer2 to pad B2
  input wire logic buzzer_two, // Buzzer2 value
  input wire logic [1:0] sink_current_cfg, // Per port A,B current bit
  input wire logic [1:0] constant_sink_cfg, // Per port A,B constant bit
  input wire logic [1:0] small_sink_cfg, // Per port A,B small-sink bit
  input wire logic [1:0] drive_cfg, // Per port A,B drive bit
  output logic [3:0] sink_mode, // Port B [3:2], port A [1:0]
  output logic [1:0] drive_large, // 1 = large drive
  input wire logic [7:0] pa_i, // Port A pad level
  output logic [7:0] pa_o, // Port A drive value
  output logic [7:0] pa_oe_n, // Port A enable, low drives
  output logic [7:0] pa_pu, // Port A pull-high on
  output logic [7:0] pa_pd, // Port A pull-low on
  input wire logic [5:0] pb_i, // Port B pad level
  output logic [5:0] pb_o, // Port B drive value
  output logic [5:0] pb_oe_n, // Port B enable, low drives
  output logic [5:0] pb_pu, // Port B pull-high on
  output logic [5:0] pb_pd // Port B pull-low on
);
  logic [7:0] latch_a_q;
  logic [5:0] latch_b_q;
  logic [7:0] prev_a_q;
  logic [5:0] prev_b_q;
  logic chg_q;
  logic chg_d;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latch_a_q <= pad_io_pkg::RST_PA;
      latch_b_q <= pad_io_pkg::RST_PB;
    end else begin
      if (data_a_we) latch_a_q <= wdata;
      if (data_b_we) latch_b_q <= wdata[5:0];
    end
  end

  // Peripheral overrides on pad output values
  wire ir_en = ir_ctrl_reg[pad_io_pkg::IR_EN_BIT];
  wire ir_on_a = ir_en & ir_large_cfg;
  wire ir_on_b = ir_en & ~ir_large_cfg;
  wire clk_on_a7 = clk_out_cfg & ~xtal_cfg;
  wire b3_per = cmp_out_en | pwm_one_out_en | buzzer_one_en;
  wire b3_val = cmp_out_en ? cmp_out :
                pwm_one_out_en ? pwm_one :
                buzzer_one;
  wire b2_per = pwm_two_out_en | buzzer_two_en;
  wire b2_val = pwm_two_out_en ? pwm_two : buzzer_two;

  logic [7:0] a_val;
  logic [7:0] a_force;
  logic [7:0] a_od;
  logic [7:0] a_ph;
  logic [7:0] a_pl;
  logic [5:0] b_val;
  logic [5:0] b_force;
  logic [5:0] b_pl;
  logic [7:0] a_rd;
  logic [5:0] b_rd;
  logic [7:0] a_oen_raw;
  logic [5:0] b_oen_raw;

  always_comb begin
    a_val = latch_a_q;
    a_force = 8'h00;
    a_val[pad_io_pkg::PA_IR] = ir_on_a ? ir_carrier : latch_a_q[pad_io_pkg::PA_IR];
    a_force[pad_io_pkg::PA_IR] = ir_on_a;
    a_val[pad_io_pkg::PA_XOUT] = clk_on_a7 ? instr_clk : latch_a_q[pad_io_pkg::PA_XOUT];
    a_force[pad_io_pkg::PA_XOUT] = clk_on_a7;
    a_od = 8'h00;
    a_od[pad_io_pkg::PA_RST] = 1'b1;
    a_ph = data_a_pullhigh_ctrl;
    a_ph[pad_io_pkg::PA_RST] = power_ctrl[pad_io_pkg::PWR_PA5_PH_BIT];
    a_pl = {4'h0, pulllow_ctrl[3:0]};
    a_pl[pad_io_pkg::PA_RST] = data_a_pullhigh_ctrl[pad_io_pkg::PAPH_PA5_PL_BIT];
    b_val = latch_b_q;
    b_force = 6'h00;
    b_val[pad_io_pkg::PB_IRQ1] = ir_on_b ? ir_carrier : latch_b_q[pad_io_pkg::PB_IRQ1];
    b_force[pad_io_pkg::PB_IRQ1] = ir_on_b;
    b_val[pad_io_pkg::PB_PWM2] = b2_per ? b2_val : latch_b_q[pad_io_pkg::PB_PWM2];
    b_force[pad_io_pkg::PB_PWM2] = b2_per;
    b_val[pad_io_pkg::PB_CMP] = b3_per ? b3_val : latch_b_q[pad_io_pkg::PB_CMP];
    b_force[pad_io_pkg::PB_CMP] = b3_per;
    b_pl = {2'h0, pulllow_ctrl[pad_io_pkg::PL_PB_LSB +: 4]};
  end

  genvar gi;
  generate
    for (gi = 0; gi < pad_io_pkg::PA_W; gi++) begin : g_pa
      pad_cell u_cell (
        .dir_in(data_a_direction[gi]),
        .out_val(a_val[gi]),
        .force_out(a_force[gi]),
        .od_en(a_od[gi]),
        .ph_en(a_ph[gi]),
        .pl_en(a_pl[gi]),
        .pad_i(pa_i[gi]),
        .rd_latch(rd_latch_a[gi]),
        .pad_o(pa_o[gi]),
        .pad_oe_n(a_oen_raw[gi]),
        .pu_on(pa_pu[gi]),
        .pd_on(pa_pd[gi]),
        .rd_val(a_rd[gi])
      );
    end
    for (gi = 0; gi < pad_io_pkg::PB_W; gi++) begin : g_pb
      pad_cell u_cell (
        .dir_in(data_b_direction[gi]),
        .out_val(b_val[gi]),
        .force_out(b_force[gi]),
        .od_en(data_b_opendrain_ctrl[gi]),
        .ph_en(data_b_pullhigh_ctrl[gi]),
        .pl_en(b_pl[gi]),
        .pad_i(pb_i[gi]),
        .rd_latch(rd_latch_b[gi]),
        .pad_o(pb_o[gi]),
        .pad_oe_n(b_oen_raw[gi]),
        .pu_on(pb_pu[gi]),
        .pd_on(pb_pd[gi]),
        .rd_val(b_rd[gi])
      );
    end
  endgenerate

  // Crystal or reset use releases the pad from general I/O
  wire [7:0] a_release = {xtal_cfg, xtal_cfg, rst_pad_cfg, 5'h00};
  assign pa_oe_n = a_oen_raw | a_release;
  assign pb_oe_n = b_oen_raw;
  assign data_a = a_rd;
  assign data_b = b_rd;

  assign ext_rst_n = ~rst_pad_cfg | pa_i[pad_io_pkg::PA_RST];
  assign xtal_in = xtal_cfg & pa_i[pad_io_pkg::PA_XIN];

  wire cki_a = pa_i[pad_io_pkg::PA_CKI_A];
  wire cki_b = pa_i[pad_io_pkg::PA_CKI_B];
  assign tmr0_ext_clk = tmr0_src_sel & ~tmr0_lowclk_sel & cki_a;
  assign tmr1_ext_clk = tmr1_src_sel & cki_a;
  assign tmr2_ext_clk = tmr2_src_sel & cki_b;
  assign tmr3_ext_clk = tmr3_src_sel & cki_b;

  wire ext_irq0_select = ext_irq_edge_reg[pad_io_pkg::EDGE_IRQ0_SEL_BIT];
  wire ext_irq1_select = ext_irq_edge_reg[pad_io_pkg::EDGE_IRQ1_SEL_BIT];
  assign ext_irq0_pin = ext_irq0_select & pb_i[pad_io_pkg::PB_IRQ0];
  assign ext_irq1_pin = ext_irq1_select & pb_i[pad_io_pkg::PB_IRQ1];

  // Level-change detect; external interrupt use masks B0 and B1
  wire [5:0] data_b_wake_en = data_b_wake_mask
                             & ~{4'h0, ext_irq1_select, ext_irq0_select};
  wire [7:0] chg_a = (pa_i ^ prev_a_q) & data_a_wake_mask;
  wire [5:0] chg_b = (pb_i ^ prev_b_q) & data_b_wake_en;
  wire data_b_wake_flag_set = (|chg_a) | (|chg_b);
  wire flag_wr_clr = flag_clr_we & ~flag_wdata[pad_io_pkg::FLAG_PORT_CHG_BIT];

  // Set wins over a clear in the same cycle so no change is lost
  assign chg_d = data_b_wake_flag_set ? 1'b1 :
                 flag_wr_clr ? 1'b0 : chg_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_a_q <= pad_io_pkg::RST_PA;
      prev_b_q <= pad_io_pkg::RST_PB;
      chg_q <= 1'b0;
    end else begin
      prev_a_q <= pa_i;
      prev_b_q <= pb_i;
      chg_q <= chg_d;
    end
  end

  always_comb begin
    irq_flag_reg = 8'h00;
    irq_flag_reg[pad_io_pkg::FLAG_PORT_CHG_BIT] = chg_q;
  end
  assign port_irq = chg_q & irq_enable_reg[pad_io_pkg::EN_PORT_CHG_BIT]
                    & power_ctrl_one[pad_io_pkg::GLOBAL_IRQ_EN_BIT];

  function automatic logic [1:0] sink_dec(input logic cur, input logic cst, input logic sml);
    if (!sml) sink_dec = pad_io_pkg::SINK_SMALL;
    else if (!cur) sink_dec = pad_io_pkg::SINK_NORMAL;
    else if (!cst) sink_dec = pad_io_pkg::SINK_LARGE;
    else sink_dec = pad_io_pkg::SINK_CONST;
  endfunction
  assign sink_mode[1:0] = sink_dec(sink_current_cfg[0], constant_sink_cfg[0],
                                   small_sink_cfg[0]);
  assign sink_mode[3:2] = sink_dec(sink_current_cfg[1], constant_sink_cfg[1],
                                   small_sink_cfg[1]);
  assign drive_large = drive_cfg;

  a_flag_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ((|((pa_i ^ $past(pa_i)) & data_a_wake_mask)) |=> chg_q))
    else $error("change flag not set on masked change");
  a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (chg_q && !flag_clr_we) |=> chg_q)
    else $error("change flag cleared without write");
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    port_irq |-> (chg_q && power_ctrl_one[7] && irq_enable_reg[1]))
    else $error("request without enables");
  a_b0_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ext_irq0_select && ext_irq1_select && data_a_wake_mask == 8'h00
     && data_b_wake_mask[5:2] == 4'h0 && !chg_q && !flag_clr_we) |=> !chg_q)
    else $error("external pad set change flag");
  a_b3_prio: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmp_out_en |-> (pb_o[3] == cmp_out && !pb_oe_n[3] || data_b_opendrain_ctrl[3]))
    else $error("comparator not on pad B3");
  a_a5_od: assert property (@(posedge clk_sys) disable iff (!rst_n)
    latch_a_q[5] |-> pa_oe_n[5])
    else $error("pad A5 drove a high level");
  a_read_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rd_latch_a[0] ? data_a[0] == latch_a_q[0] : data_a[0] == pa_i[0]))
    else $error("read select wrong");
  a_ir_pad: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ir_en && !ir_large_cfg) |-> (pb_o[1] == ir_carrier && !pb_oe_n[1]
     || data_b_opendrain_ctrl[1]))
    else $error("carrier missing on pad B1");

  // Pad routing is combinational, so these hold in the cycle they are sampled, except a_write_lands, checked one cycle after the strobe
  a_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
    data_a_we |=> (latch_a_q == $past(wdata)))
    else $error("port A write not latched");
  a_out_no_pull: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !data_a_direction[0] |-> !pa_pu[0])
    else $error("pull-high on an output pad");
  a_b5_pullhigh: assert property (@(posedge clk_sys) disable iff (!rst_n)
    data_b_direction[5] |-> (pb_pu[5] == data_b_pullhigh_ctrl[5]))
    else $error("pad B5 pull-high wrong");
  a_a5_pullhigh: assert property (@(posedge clk_sys) disable iff (!rst_n)
    data_a_direction[5] |-> (pa_pu[5] == power_ctrl[4]))
    else $error("pad A5 pull-high not from power control");
  a_b0_pulllow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    data_b_direction[0] |-> (pb_pd[0] == pulllow_ctrl[4]))
    else $error("pad B0 pull-low wrong");
  a_b0_opendrain: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!data_b_direction[0] && data_b_opendrain_ctrl[0] && pb_o[0]) |-> pb_oe_n[0])
    else $error("open-drain pad B0 drove a high level");
  a_irq_raise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (chg_q && irq_enable_reg[1] && power_ctrl_one[7]) |-> port_irq)
    else $error("enabled change flag gave no request");
  a_ext_irq_pins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ext_irq0_pin == (ext_irq_edge_reg[4] && pb_i[0]))
    && (ext_irq1_pin == (ext_irq_edge_reg[5] && pb_i[1])))
    else $error("external interrupt pin steering wrong");
  a_ir_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!ir_ctrl_reg[0] && data_a_direction[3]) |-> pa_oe_n[3])
    else $error("pad A3 driven with carrier off");
  a_rst_pad: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_pad_cfg |-> (pa_oe_n[5] && ext_rst_n == pa_i[5]))
    else $error("pad A5 reset use wrong");
  a_xtal_pads: assert property (@(posedge clk_sys) disable iff (!rst_n)
    xtal_cfg |-> (pa_oe_n[7:6] == 2'h3 && xtal_in == pa_i[6]))
    else $error("crystal pads not released");
  a_clk_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_out_cfg && !xtal_cfg) |-> (!pa_oe_n[7] && pa_o[7] == instr_clk))
    else $error("instruction clock missing on pad A7");
  a_tmr_clk_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tmr0_ext_clk == (tmr0_src_sel && !tmr0_lowclk_sel && pa_i[4]))
    && (tmr1_ext_clk == (tmr1_src_sel && pa_i[4])))
    else $error("timer clock A routing wrong");
  a_tmr_clk_b: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tmr2_ext_clk == (tmr2_src_sel && pa_i[1]))
    && (tmr3_ext_clk == (tmr3_src_sel && pa_i[1])))
    else $error("timer clock B routing wrong");
  a_b2_prio: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwm_two_out_en && !data_b_opendrain_ctrl[2]) |-> (!pb_oe_n[2] && pb_o[2] == pwm_two))
    else $error("PWM2 not on pad B2");
  a_sink_small: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (small_sink_cfg[0] || sink_mode[1:0] == pad_io_pkg::SINK_SMALL)
    && (small_sink_cfg[1] || sink_mode[3:2] == pad_io_pkg::SINK_SMALL))
    else $error("small sink not selected");
endmodule
`default_nettype wire

// >>> dv/pad_board_model.sv
/*
 Board side of one port: resolves each pad from the block's drive, the
 board's own drivers, and the pulls the block turns on.
 Assumes one system clock; a floating pad flips each cycle so no stale
 level is mistaken for a real one.
*/
`default_nettype none
module pad_board_model #(
  parameter int W = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic [W-1:0] pad_o, // Block drive value
  input wire logic [W-1:0] pad_oe_n, // Block enable, low drives
  input wire logic [W-1:0] pu, // Pull-high on
  input wire logic [W-1:0] pd, // Pull-low on
  input wire logic [W-1:0] ext_v, // Board drive value
  input wire logic [W-1:0] ext_en, // Board drives pad
  output logic [W-1:0] pad_i // Resolved level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [W-1:0] last_q;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!pad_oe_n[i]) begin
        pad_i[i] = pad_o[i];
      end else if (ext_en[i]) begin
        pad_i[i] = ext_v[i];
      end else if (pu[i]) begin
        pad_i[i] = 1'b1;
      end else if (pd[i]) begin
        pad_i[i] = 1'b0;
      end else begin
        pad_i[i] = ~last_q[i];
      end
    end
  end
  always_ff @(posedge clk_sys) last_q <= pad_i;
endmodule
`default_nettype wire

// >>> dv/pad_io_port_tb_top.sv
/*
 Self-checking bench for the pad I/O port block.
 Assumes the block's control bits are plain ports and board models close
 each pad loop.
*/
`default_nettype none
module pad_io_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0, rst_n = 0, data_a_we = 0, data_b_we = 0, flag_clr_we = 0;
  logic ir_large_cfg = 0, ir_carrier = 0, rst_pad_cfg = 0, xtal_cfg = 0;
  logic clk_out_cfg = 0, instr_clk = 0, tmr0_src_sel = 0, tmr0_lowclk_sel = 0;
  logic tmr1_src_sel = 0, tmr2_src_sel = 0, tmr3_src_sel = 0, cmp_out_en = 0;
  logic cmp_out = 0, pwm_one_out_en = 0, pwm_one = 0, buzzer_one_en = 0;
  logic buzzer_one = 0, pwm_two_out_en = 0, pwm_two = 0, buzzer_two_en = 0;
  logic buzzer_two = 0;
  logic [7:0] wdata = 8'h00, data_a_direction = 8'hFF, rd_latch_a = 8'hFF;
  logic [7:0] data_a_pullhigh_ctrl = 8'h00, pulllow_ctrl = 8'h00, power_ctrl = 8'h00;
  logic [7:0] data_a_wake_mask = 8'h00, flag_wdata = 8'h00, irq_enable_reg = 8'h00;
  logic [7:0] power_ctrl_one = 8'h00, ext_irq_edge_reg = 8'h00, ir_ctrl_reg = 8'h00;
  logic [7:0] ext_va = 8'h00, ext_ea = 8'hFF;
  logic [5:0] data_b_direction = 6'h3F, rd_latch_b = 6'h3F, data_b_pullhigh_ctrl = 6'h00;
  logic [5:0] data_b_opendrain_ctrl = 6'h00, data_b_wake_mask = 6'h00;
  logic [5:0] ext_vb = 6'h00, ext_eb = 6'h3F;
  logic [1:0] sink_current_cfg = 2'h0, constant_sink_cfg = 2'h0;
  logic [1:0] small_sink_cfg = 2'h0, drive_cfg = 2'h0, drive_large;
  logic [7:0] data_a, irq_flag_reg, pa_i, pa_o, pa_oe_n, pa_pu, pa_pd;
  logic [5:0] data_b, pb_i, pb_o, pb_oe_n, pb_pu, pb_pd;
  logic port_irq, ext_irq0_pin, ext_irq1_pin, ext_rst_n, xtal_in;
  logic tmr0_ext_clk, tmr1_ext_clk, tmr2_ext_clk, tmr3_ext_clk;
  logic [3:0] sink_mode;
  int errors = 0, compares = 0, cycles = 0;

  pad_io_port u_pad_io_port (.clk_sys, .rst_n, .data_a_we, .data_b_we, .wdata,
    .data_a, .data_b, .data_a_direction, .data_b_direction, .rd_latch_a, .rd_latch_b,
    .data_a_pullhigh_ctrl, .data_b_pullhigh_ctrl, .pulllow_ctrl, .power_ctrl,
    .data_b_opendrain_ctrl, .data_a_wake_mask, .data_b_wake_mask, .flag_clr_we,
    .flag_wdata, .irq_flag_reg, .irq_enable_reg, .power_ctrl_one, .port_irq,
    .ext_irq_edge_reg, .ext_irq0_pin, .ext_irq1_pin, .ir_ctrl_reg, .ir_large_cfg,
    .ir_carrier, .rst_pad_cfg, .ext_rst_n, .xtal_cfg, .clk_out_cfg, .instr_clk,
    .xtal_in, .tmr0_src_sel, .tmr0_lowclk_sel, .tmr1_src_sel, .tmr2_src_sel,
    .tmr3_src_sel, .tmr0_ext_clk, .tmr1_ext_clk, .tmr2_ext_clk, .tmr3_ext_clk,
    .cmp_out_en, .cmp_out, .pwm_one_out_en, .pwm_one, .buzzer_one_en, .buzzer_one,
    .pwm_two_out_en, .pwm_two, .buzzer_two_en, .buzzer_two, .sink_current_cfg,
    .constant_sink_cfg, .small_sink_cfg, .drive_cfg, .sink_mode, .drive_large,
    .pa_i, .pa_o, .pa_oe_n, .pa_pu, .pa_pd, .pb_i, .pb_o, .pb_oe_n, .pb_pu, .pb_pd);
  pad_board_model #(.W(8)) u_pad_board_model_a (.clk_sys, .pad_o(pa_o),
    .pad_oe_n(pa_oe_n), .pu(pa_pu), .pd(pa_pd), .ext_v(ext_va), .ext_en(ext_ea),
    .pad_i(pa_i));
  pad_board_model #(.W(6)) u_pad_board_model_b (.clk_sys, .pad_o(pb_o),
    .pad_oe_n(pb_oe_n), .pu(pb_pu), .pd(pb_pd), .ext_v(ext_vb), .ext_en(ext_eb),
    .pad_i(pb_i));

  initial forever #12.5 clk_sys = ~clk_sys;

  task automatic results();
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Strobe taken at the second edge; settle before returning
  task automatic wr(input bit b, input logic [7:0] v);
    @(posedge clk_sys);
    data_a_we <= !b;
    data_b_we <= b;
    wdata <= v;
    @(posedge clk_sys);
    data_a_we <= 0;
    data_b_we <= 0;
    #2;
  endtask

  task automatic clr();
    @(posedge clk_sys);
    flag_clr_we <= 1;
    flag_wdata <= 8'h00;
    @(posedge clk_sys);
    flag_clr_we <= 0;
    #2;
  endtask

  // Stimulus goes in after an edge; the flag is seen one edge later
  task automatic pulse_pad(input logic [7:0] va, input logic [5:0] vb);
    @(posedge clk_sys);
    ext_va <= va;
    ext_vb <= vb;
    @(posedge clk_sys);
    #2;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      results();
    end
  end

  initial begin
    int k;
    logic [1:0] e;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1;
    data_a_direction <= 8'h00;
    wr(0, 8'hA5);
    chk("data_a", 8'hA5, data_a);
    chk("pa_oe_n", 8'h20, pa_oe_n);
    chk("pa_o", 8'h85, pa_o & 8'hDF);
    @(posedge clk_sys);
    data_a_direction <= 8'hFF;
    rd_latch_a <= 8'h00;
    ext_va <= 8'h3C;
    data_a_pullhigh_ctrl <= 8'hFF;
    pulllow_ctrl <= 8'h5A;
    #2;
    chk("data_a", 8'h3C, data_a);
    chk("pa_pu", 8'hDF, pa_pu);
    chk("pa_pd", 8'h2A, pa_pd);
    chk("pb_pd", 8'h05, pb_pd);
    @(posedge clk_sys);
    power_ctrl <= 8'h10;
    data_b_pullhigh_ctrl <= 6'h2A;
    ext_ea <= 8'h00;
    #2;
    chk("pa_pu", 8'hFF, pa_pu);
    chk("pb_pu", 8'h2A, pb_pu);
    chk("data_a", 8'hFF, data_a);
    @(posedge clk_sys);
    data_a_direction <= 8'h00;
    ext_ea <= 8'hFF;
    data_b_direction <= 6'h00;
    data_b_opendrain_ctrl <= 6'h3F;
    rd_latch_b <= 6'h0F;
    wr(1, 8'h15);
    chk("data_b", 8'h05, data_b);
    chk("pa_pu", 8'h00, pa_pu);
    chk("pb_oe_n", 8'h15, pb_oe_n);
    @(posedge clk_sys);
    data_b_opendrain_ctrl <= 6'h00;
    #2;
    chk("pb_oe_n", 8'h00, pb_oe_n);
    // Board drives every pad for the change-flag checks; the block's outputs are released
    @(posedge clk_sys);
    data_a_direction <= 8'hFF;
    data_b_direction <= 6'h3F;
    irq_enable_reg <= 8'h02;
    power_ctrl_one <= 8'h80;
    data_a_wake_mask <= 8'h01;
    clr();
    pulse_pad(8'h3D, 6'h00);
    chk("flag", 8'h02, irq_flag_reg);
    chk("port_irq", 8'h01, port_irq);
    repeat (5) @(posedge clk_sys);
    power_ctrl_one <= 8'h00;
    #2;
    chk("flag", 8'h02, irq_flag_reg);
    chk("port_irq", 8'h00, port_irq);
    @(posedge clk_sys);
    power_ctrl_one <= 8'h80;
    irq_enable_reg <= 8'h00;
    #2;
    chk("port_irq", 8'h00, port_irq);
    data_a_wake_mask <= 8'h00;
    data_b_wake_mask <= 6'h03;
    ext_irq_edge_reg <= 8'h30;
    clr();
    chk("flag", 8'h00, irq_flag_reg);
    pulse_pad(8'h3D, 6'h03);
    chk("flag", 8'h00, irq_flag_reg);
    chk("ext_irq", 8'h03, {ext_irq1_pin, ext_irq0_pin});
    ext_irq_edge_reg <= 8'h00;
    pulse_pad(8'h3D, 6'h02);
    chk("flag", 8'h02, irq_flag_reg);
    chk("ext_irq", 8'h00, {ext_irq1_pin, ext_irq0_pin});
    data_b_wake_mask <= 6'h04;
    ext_irq_edge_reg <= 8'h30;
    clr();
    pulse_pad(8'h3D, 6'h06);
    chk("flag", 8'h02, irq_flag_reg);
    for (k = 0; k < 6; k++) begin
      @(posedge clk_sys);
      ir_ctrl_reg <= {7'h00, k[2] | k[1]};
      ir_large_cfg <= k[0];
      ir_carrier <= k[1];
      #2;
      e = k[0] ? 2'b01 : 2'b10;
      chk("ir_oe", (k < 2) ? 8'h03 : {6'h00, e}, {pa_oe_n[3], pb_oe_n[1]});
      if (k >= 2) chk("ir_val", k[1], k[0] ? pa_o[3] : pb_o[1]);
    end
    @(posedge clk_sys);
    ir_ctrl_reg <= 8'h00;
    rst_pad_cfg <= 1;
    xtal_cfg <= 1;
    ext_va <= 8'h40;
    data_a_direction <= 8'h00;
    #2;
    chk("ext_rst_n", 8'h00, ext_rst_n);
    chk("xtal_in", 8'h01, xtal_in);
    chk("pa_oe_n", 8'hE0, pa_oe_n & 8'hE0);
    @(posedge clk_sys);
    ext_va <= 8'h20;
    #2;
    chk("ext_rst_n", 8'h01, ext_rst_n);
    chk("xtal_in", 8'h00, xtal_in);
    for (k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      data_a_direction <= 8'hFF;
      xtal_cfg <= (k == 2);
      clk_out_cfg <= 1;
      instr_clk <= !k[0];
      #2;
      chk("a7", (k == 2) ? 8'h02 : {7'h00, !k[0]},
        {pa_oe_n[7], pa_o[7] & !pa_oe_n[7]});
    end
    @(posedge clk_sys);
    ext_va <= 8'h12;
    for (k = 0; k < 32; k++) begin
      @(posedge clk_sys);
      {tmr3_src_sel, tmr2_src_sel, tmr1_src_sel, tmr0_lowclk_sel, tmr0_src_sel} <= k[4:0];
      #2;
      chk("tmr_clk", {k[4:2], k[0] & !k[1]},
        {tmr3_ext_clk, tmr2_ext_clk, tmr1_ext_clk, tmr0_ext_clk});
    end
    @(posedge clk_sys);
    ext_va <= 8'h00;
    #2;
    chk("tmr_clk", 8'h00, {tmr3_ext_clk, tmr2_ext_clk, tmr1_ext_clk});
    data_b_direction <= 6'h00;
    wr(1, 8'h00);
    for (k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      {cmp_out_en, pwm_one_out_en, buzzer_one_en} <= k[2:0];
      {pwm_two_out_en, buzzer_two_en} <= k[1:0];
      cmp_out <= (k == 0) | k[2];
      pwm_one <= (k == 0) | (k[2:1] == 2'b01);
      buzzer_one <= (k == 0) | (k == 1);
      pwm_two <= (k == 0) | k[1];
      buzzer_two <= (k == 0) | (k[1:0] == 2'b01);
      #2;
      chk("pb32", {6'h00, k != 0, k[1:0] != 0},
        {pb_o[3:2] & ~pb_oe_n[3:2]});
    end
    for (k = 0; k < 8; k++) begin
      if (k == 6) continue;
      @(posedge clk_sys);
      sink_current_cfg <= {2{k[0]}};
      constant_sink_cfg <= {2{k[1]}};
      small_sink_cfg <= {2{k[2]}};
      drive_cfg <= k[1:0];
      #2;
      e = !k[2] ? pad_io_pkg::SINK_SMALL : !k[0] ? pad_io_pkg::SINK_NORMAL :
        k[1] ? pad_io_pkg::SINK_CONST : pad_io_pkg::SINK_LARGE;
      chk("sink_mode", {4'h0, e, e}, sink_mode);
      chk("drive_large", k[1:0], drive_large);
    end
    results();
  end
endmodule
`default_nettype wire
